// ### bench/gap_reader.sv
// Reader model that sends pulse-interval write commands on the gap line
`timescale 1ns/1ps
`default_nettype none
module gap_reader
(
   // Field side
   input  wire logic field_clk,
   output logic      gap_pin
);
   // ************************************************************
   // Command sender
   // ************************************************************
   initial gap_pin = 1'b0;

   task automatic pulse(input int wd, input int iv);
      gap_pin <= 1'b1;
      repeat (wd) @(posedge field_clk);
      gap_pin <= 1'b0;
      repeat (iv - wd) @(posedge field_clk);
   endtask

   // Line idles low between gaps; bad_at swaps one interval for bad_iv
   task automatic send(input logic f, input logic [7:0] w, input int n,
                       input int bad_at, input int bad_iv);
      int iv;
      @(posedge field_clk);
      for (int i = 0; i <= n; i++)
      begin
         iv = (i == n) ? 8 : (w[n-1-i] ? (f ? 27 : 56) : (f ? 12 : 24));
         if (i == bad_at) iv = bad_iv;
         pulse((i == 0) ? 10 : 8, iv);
      end
   endtask
endmodule // gap_reader
`default_nettype wire

// ### bench/rf_tag_gap_decode_and_output_options_tb.sv
// Testbench for the tag link
`timescale 1ns/1ps
`default_nettype none
module rf_tag_gap_decode_and_output_options_tb;
   import tag_pkg::*;
   logic        clk_sys, sys_rst, field_clk, hsel, hwrite, seq_start, bit_tick, data_bit;
   logic [7:0]  haddr;
   logic [1:0]  htrans;
   logic [2:0]  hsize, restart_block;
   logic [31:0] hwdata, hrdata, q;
   logic        hreadyout, hresp, gap_pin, data_take, mod_bit;
   logic        write_mode, prog_busy, read_restart;
   int          num_errors, comparisons;

   tag_link i_dut (.clk_sys, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize,
      .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp, .field_clk, .gap_pin,
      .seq_start, .bit_tick, .data_bit, .data_take, .mod_bit, .write_mode, .prog_busy,
      .read_restart, .restart_block);
   gap_reader i_reader (.field_clk, .gap_pin);

   // ************************************************************
   // Clocks and shared tasks
   // ************************************************************
   initial
   begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end
   // Field clock offset so the two domains never line up
   initial
   begin
      field_clk = 1'b0;
      #7;
      forever #15 field_clk = ~field_clk;
   end

   task automatic end_sim;
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic timeout(input string nm);
      num_errors++;
      $display("[FAIL] %s expected done seen timeout", nm);
      end_sim;
   endtask
   task automatic wait_rdy;
      int k;
      for (k = 0; k < 20; k++)
      begin
         @(posedge clk_sys);
         if (hreadyout === 1'b1) break;
      end
      if (k == 20) timeout("hready");
   endtask
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      wait_rdy;
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy;
      q = hrdata;
   endtask
   task automatic wait_fld(input string nm, input logic sel, input int max, output int k);
      for (k = 0; k < max; k++)
      begin
         @(posedge field_clk);
         if ((sel ? read_restart : prog_busy) === 1'b1) break;
      end
      if (k == max) timeout(nm);
   endtask
   task automatic tick(input logic d, output logic m, output logic t);
      @(posedge field_clk);
      bit_tick <= 1'b1;
      data_bit <= d;
      @(posedge field_clk);
      bit_tick <= 1'b0;
      // Take pulse lasts one field cycle only
      #1 t = data_take;
      @(posedge field_clk);
      #1 m = mod_bit;
   endtask

   // ************************************************************
   // Scenarios
   // ************************************************************
   task automatic reg_test;
      ahb(1'b0, CFG_OFS, 32'h0);
      check("cfg reset", q[7:0], CFG_RST);
      check("okay resp", hresp, 1'b0);
      ahb(1'b1, CFG_OFS, 32'hFFFF_FFFF);
      ahb(1'b0, CFG_OFS, 32'h0);
      check("cfg rw", q[7:0], 8'hFF);
      ahb(1'b1, STAT_OFS, 32'hFFFF_FFFF);
      ahb(1'b0, STAT_OFS, 32'h0);
      check("stat ro", q[2:0], 3'h0);
      ahb(1'b0, 8'h10, 32'h0);
      check("unmapped", q, 32'h0);
   endtask
   task automatic cmd_test(input logic f, input logic [7:0] w, input int lo, input int hi);
      int k;
      ahb(1'b1, CFG_OFS, {24'h0, f, 7'h0});
      repeat (6) @(posedge field_clk);
      i_reader.send(f, w, 8, -1, 0);
      check("write mode", write_mode, 1'b1);
      wait_fld("prog start", 1'b0, 80, k);
      check("quiet limit", (k + 8 >= lo) && (k + 8 <= hi), 1'b1);
      wait_fld("prog end", 1'b1, 800, k);
      check("prog time", (k >= 700) && (k <= 715), 1'b1);
      repeat (6) @(posedge clk_sys);
      ahb(1'b0, RXW_OFS, 32'h0);
      check("rx word", q[7:0], w);
      ahb(1'b0, RXN_OFS, 32'h0);
      check("rx count", q[5:0], 6'h08);
   endtask
   task automatic bad_test(input logic f, input int bad_iv);
      int k;
      ahb(1'b1, CFG_OFS, {24'h0, f, 7'h0});
      repeat (6) @(posedge field_clk);
      fork
         i_reader.send(f, 8'hFF, 4, 3, bad_iv);
         wait_fld("error restart", 1'b1, 300, k);
      join
      check("restart block", restart_block, RESTART_BLK);
      repeat (100) @(posedge field_clk);
      check("no prog", prog_busy, 1'b0);
   endtask
   task automatic out_test(input logic [7:0] cfg, input logic ext, input logic inv);
      logic [1:0] h, g;
      logic       m, t;
      ahb(1'b1, CFG_OFS, {24'h0, cfg});
      repeat (6) @(posedge field_clk);
      ahb(1'b0, STAT_OFS, 32'h0);
      check("ext active", q[2], ext);
      for (int s = 0; s < 2; s++)
      begin
         @(posedge field_clk);
         seq_start <= 1'b1;
         @(posedge field_clk);
         seq_start <= 1'b0;
         if (ext) tick(1'b1, g[1], t);
         if (ext) tick(1'b1, g[0], t);
         if (ext) check("header take", t, 1'b0);
         if (ext && s == 0) check("header form", g[1] ^ g[0], 1'b1);
         if (ext && s == 1) check("header flip", g ^ h, 2'h3);
         h = g;
         tick(1'b1, m, t);
         check("data one", m, 1'b1 ^ inv);
         check("data take", t, 1'b1);
         tick(1'b0, m, t);
         check("data zero", m, inv);
      end
   endtask

   // ************************************************************
   // Main sequence
   // ************************************************************
   initial
   begin
      {hsel, hwrite, seq_start, bit_tick, data_bit} = 5'h00;
      haddr = 8'h00;
      htrans = 2'h0;
      hsize = 3'h2;
      hwdata = 32'h0;
      num_errors = 0;
      comparisons = 0;
      sys_rst = 1'b1;
      repeat (3) @(posedge clk_sys);
      sys_rst <= 1'b0;
      repeat (6) @(posedge field_clk);
      reg_test;
      cmd_test(1'b0, 8'hA5, 64, 73);
      cmd_test(1'b1, 8'h3C, 33, 42);
      bad_test(1'b0, 40);
      bad_test(1'b1, 20);
      out_test(8'h76, 1'b1, 1'b1);
      out_test(8'h39, 1'b1, 1'b0);
      out_test(8'h75, 1'b0, 1'b0);
      out_test(8'h66, 1'b0, 1'b0);
      end_sim;
   end
   initial
   begin
      repeat (100000) @(posedge clk_sys);
      timeout("run");
   end
endmodule // rf_tag_gap_decode_and_output_options_tb
`default_nettype wire

// ### bench/tag_link_sva.sv
// Checker for the tag link field-side timing
`timescale 1ns/1ps
`default_nettype none
module tag_link_sva
(
   // Reset
   input wire logic       sys_rst,
   // Field side
   input wire logic       field_clk,
   input wire logic       gap_pin,
   input wire logic       seq_start,
   input wire logic       bit_tick,
   input wire logic       data_take,
   input wire logic       mod_bit,
   input wire logic       write_mode,
   input wire logic       prog_busy,
   input wire logic       read_restart,
   input wire logic [2:0] restart_block
);
   // ************************************************************
   // Helper counters
   // ************************************************************
   // Field reset lags sys_rst, so keep checks off a few cycles longer
   logic [3:0] rst_hist_r, rst_hist_nxt;
   logic [9:0] busy_cnt_r, busy_cnt_nxt;
   logic [3:0] quiet_r, quiet_nxt;
   logic       hold_off;
   assign hold_off = sys_rst | (|rst_hist_r);
   always_comb
   begin
      rst_hist_nxt = {rst_hist_r[2:0], sys_rst};
      busy_cnt_nxt = (prog_busy && !hold_off) ? busy_cnt_r + 10'h001 : 10'h000;
      quiet_nxt = gap_pin ? 4'h0 : ((quiet_r == 4'hF) ? 4'hF : quiet_r + 4'h1);
   end
   always_ff @(posedge field_clk)
   begin
      rst_hist_r <= rst_hist_nxt;
      busy_cnt_r <= busy_cnt_nxt;
      quiet_r    <= quiet_nxt;
   end
   // ************************************************************
   // Properties
   // ************************************************************
   a_prog_length: assert property (@(posedge field_clk) disable iff (hold_off)
      $fell(prog_busy) |-> busy_cnt_r == 10'h2C8) else $error("prog length wrong");
   a_prog_restart: assert property (@(posedge field_clk) disable iff (hold_off)
      $fell(prog_busy) |-> ##[0:2] read_restart) else $error("no restart after prog");
   a_restart_pulse: assert property (@(posedge field_clk) disable iff (hold_off)
      read_restart |=> !read_restart) else $error("restart not a pulse");
   a_restart_block: assert property (@(posedge field_clk) disable iff (hold_off)
      read_restart |-> restart_block == 3'h1) else $error("restart block wrong");
   a_write_on_gap: assert property (@(posedge field_clk) disable iff (hold_off)
      $rose(write_mode) |-> quiet_r < 4'h8) else $error("write mode without gap");
   a_prog_quiet: assert property (@(posedge field_clk) disable iff (hold_off)
      $rose(prog_busy) |-> quiet_r == 4'hF) else $error("prog began too soon");
   a_mod_hold: assert property (@(posedge field_clk) disable iff (hold_off)
      !$past(bit_tick) && !$past(seq_start) |-> $stable(mod_bit)) else $error("mod bit moved");
   a_take_tick: assert property (@(posedge field_clk) disable iff (hold_off)
      data_take |-> $past(bit_tick)) else $error("take without tick");
endmodule // tag_link_sva
bind tag_link tag_link_sva i_sva (.sys_rst, .field_clk, .gap_pin, .seq_start, .bit_tick,
   .data_take, .mod_bit, .write_mode, .prog_busy, .read_restart, .restart_block);
`default_nettype wire

// ### core/gap_decoder.sv
// Field-clock gap decoder for reader write commands
`timescale 1ns/1ps
`default_nettype none
module gap_decoder
   import tag_pkg::*;
(
   // Field domain
   input  wire logic field_clk,
   input  wire logic field_rst,
   input  wire logic gap,
   input  wire logic fast,
   // Decoded stream
   output logic      bit_stb,
   output logic      bit_val,
   output logic      err_stb,
   output logic      end_stb,
   output logic      active
);
   dec_st_t       st_r, st_nxt;
   logic [CW-1:0] cnt_r, cnt_nxt;
   logic          gap_r, bstb_r, bval_r, err_r, end_r;
   logic          bstb_nxt, bval_nxt, err_nxt, end_nxt;
   logic          rise, fall, z_ok, o_ok, wg_ok;
   logic [CW-1:0] tmo;

   assign rise = gap && !gap_r;
   assign fall = !gap && gap_r;
   assign tmo  = fast ? FAST_TMO : NORM_TMO; // RL6
   // RL7 RL12
   assign z_ok  = fast ? in_win(cnt_r, F0_MIN, F0_MAX) : in_win(cnt_r, N0_MIN, N0_MAX);
   assign o_ok  = fast ? in_win(cnt_r, F1_MIN, F1_MAX) : in_win(cnt_r, N1_MIN, N1_MAX);
   assign wg_ok = in_win(cnt_r, WGAP_MIN, fast ? WFGAP_MAX : NORMAL_WRITE_GAP_TIME_MAX);

   always_comb
   begin
      st_nxt   = st_r;
      bstb_nxt = 1'b0;
      bval_nxt = bval_r;
      err_nxt  = 1'b0;
      end_nxt  = 1'b0;
      // Restart on each gap start, saturate otherwise
      cnt_nxt  = rise ? 7'h01 : ((&cnt_r) ? cnt_r : cnt_r + 7'h01); // RL11
      case (st_r)
         DEC_IDLE:
            if (rise)
               st_nxt = DEC_START_GAP_TIME;
         DEC_START_GAP_TIME:
            if (fall)
            begin
               if (in_win(cnt_r, START_GAP_TIME_MIN, START_GAP_TIME_MAX)) // RL7
                  st_nxt = DEC_BITS;
               else
               begin
                  err_nxt = 1'b1;
                  st_nxt  = DEC_IDLE;
               end
            end
            else if (cnt_r > START_GAP_TIME_MAX)
            begin
               err_nxt = 1'b1;
               st_nxt  = DEC_IDLE;
            end
         DEC_BITS:
            if (rise)
            begin
               if (z_ok || o_ok)
               begin
                  bstb_nxt = 1'b1;
                  bval_nxt = o_ok;
               end
               else
               begin
                  err_nxt = 1'b1; // RL12
                  st_nxt  = DEC_IDLE;
               end
            end
            else if (fall && !wg_ok)
            begin
               err_nxt = 1'b1; // RL7
               st_nxt  = DEC_IDLE;
            end
            else if (!gap && cnt_r > tmo)
            begin
               end_nxt = 1'b1; // RL6
               st_nxt  = DEC_IDLE;
            end
         default:
            st_nxt = DEC_IDLE;
      endcase
   end

   always_ff @(posedge field_clk)
   begin
      if (field_rst)
      begin
         st_r   <= DEC_IDLE;
         cnt_r  <= '0;
         gap_r  <= 1'b0;
         bstb_r <= 1'b0;
         bval_r <= 1'b0;
         err_r  <= 1'b0;
         end_r  <= 1'b0;
      end
      else
      begin
         st_r   <= st_nxt;
         cnt_r  <= cnt_nxt;
         gap_r  <= gap;
         bstb_r <= bstb_nxt;
         bval_r <= bval_nxt;
         err_r  <= err_nxt;
         end_r  <= end_nxt;
      end
   end

   assign bit_stb = bstb_r;
   assign bit_val = bval_r;
   assign err_stb = err_r;
   assign end_stb = end_r;
   assign active  = (st_r != DEC_IDLE);
endmodule // gap_decoder
`default_nettype wire

// ### core/tag_link.sv
// Tag link top: AHB-Lite registers, write command path and output options
`timescale 1ns/1ps
`default_nettype none
module tag_link
(
   // System side
   input  wire logic        clk_sys,
   input  wire logic        sys_rst,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [7:0]  haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic        hready,
   input  wire logic [31:0] hwdata,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // Field side
   input  wire logic        field_clk,
   input  wire logic        gap_pin,
   // Outgoing data path, field domain
   input  wire logic        seq_start,
   input  wire logic        bit_tick,
   input  wire logic        data_bit,
   output logic             data_take,
   output logic             mod_bit,
   // Mode towards the tag controller, field domain
   output logic             write_mode,
   output logic             prog_busy,
   output logic             read_restart,
   output logic      [2:0]  restart_block
);
   import tag_pkg::*;

   // ************************************************************
   // Field domain reset and input synchronisers
   // ************************************************************
   logic       frst_a_r, field_rst;
   logic       gap_a_r, gap_s_r;
   logic [7:0] cfg_a_r, cfg_f_r;
   logic [7:0] cfg_r, cfg_nxt;

   always_ff @(posedge field_clk)
   begin
      frst_a_r  <= sys_rst;
      field_rst <= frst_a_r;
      gap_a_r   <= gap_pin;
      gap_s_r   <= gap_a_r;
      // Config is quasi-static; software changes it between commands only
      cfg_a_r   <= cfg_r;
      cfg_f_r   <= cfg_a_r;
   end

   logic xm_ok, hdr_en, inv_en, fast;
   assign xm_ok  = cfg_f_r[XMODE_B] && ((cfg_f_r[KEY_LSB +: 4] == KEY_A) ||
                   (cfg_f_r[KEY_LSB +: 4] == KEY_B)); // RL9
   assign hdr_en = xm_ok && cfg_f_r[HDR_B];  // RL9
   assign inv_en = xm_ok && cfg_f_r[INV_B];  // RL9
   assign fast   = cfg_f_r[FAST_B];

   // ************************************************************
   // Write command decoding
   // ************************************************************
   logic bit_stb, bit_val, err_stb, end_stb, dec_act;

   gap_decoder u_dec (
      .field_clk (field_clk),
      .field_rst (field_rst),
      .gap       (gap_s_r),
      .fast      (fast),
      .bit_stb   (bit_stb),
      .bit_val   (bit_val),
      .err_stb   (err_stb),
      .end_stb   (end_stb),
      .active    (dec_act)
   );

   lnk_st_t          lst_r, lst_nxt;
   logic [9:0]       pcnt_r, pcnt_nxt;
   logic [31:0]      sh_r, sh_nxt, rxw_r, rxw_nxt;
   logic [RXN_W-1:0] n_r, n_nxt, rxn_r, rxn_nxt;
   logic             tgl_r, tgl_nxt, rr_r, rr_nxt;

   always_comb
   begin
      lst_nxt  = lst_r;
      pcnt_nxt = pcnt_r;
      sh_nxt   = sh_r;
      n_nxt    = n_r;
      rxw_nxt  = rxw_r;
      rxn_nxt  = rxn_r;
      tgl_nxt  = tgl_r;
      rr_nxt   = 1'b0;
      case (lst_r)
         LNK_READ:
            if (dec_act)
            begin
               lst_nxt = LNK_WRITE;
               sh_nxt  = '0;
               n_nxt   = '0;
            end
         LNK_WRITE:
            if (bit_stb)
            begin
               sh_nxt = {sh_r[30:0], bit_val};
               n_nxt  = (&n_r) ? n_r : n_r + 1'b1;
            end
            else if (err_stb)
            begin
               lst_nxt = LNK_READ; // RL10
               rr_nxt  = 1'b1;
            end
            else if (end_stb)
            begin
               lst_nxt  = LNK_PROG;
               pcnt_nxt = '0;
               rxw_nxt  = sh_r;
               rxn_nxt  = n_r;
               tgl_nxt  = !tgl_r;
            end
         LNK_PROG:
            if (pcnt_r == PROG_CYC - 10'h001)
            begin
               lst_nxt = LNK_READ; // RL8
               rr_nxt  = 1'b1;
            end
            else
               pcnt_nxt = pcnt_r + 10'h001; // RL8
         default:
            lst_nxt = LNK_READ;
      endcase
   end

   always_ff @(posedge field_clk)
   begin
      if (field_rst)
      begin
         lst_r  <= LNK_READ;
         pcnt_r <= '0;
         sh_r   <= '0;
         n_r    <= '0;
         rxw_r  <= '0;
         rxn_r  <= '0;
         tgl_r  <= 1'b0;
         rr_r   <= 1'b0;
      end
      else
      begin
         lst_r  <= lst_nxt;
         pcnt_r <= pcnt_nxt;
         sh_r   <= sh_nxt;
         n_r    <= n_nxt;
         rxw_r  <= rxw_nxt;
         rxn_r  <= rxn_nxt;
         tgl_r  <= tgl_nxt;
         rr_r   <= rr_nxt;
      end
   end

   assign write_mode    = (lst_r == LNK_WRITE);
   assign prog_busy     = (lst_r == LNK_PROG);
   assign read_restart  = rr_r;
   assign restart_block = RESTART_BLK; // RL10

   // ************************************************************
   // Outgoing bits: sequence header and inversion
   // ************************************************************
   logic [1:0] hpat_r, hpat_nxt;
   logic [1:0] hleft_r, hleft_nxt;
   logic       mod_r, mod_nxt, tk_r, tk_nxt;

   always_comb
   begin
      hpat_nxt  = hpat_r;
      hleft_nxt = hleft_r;
      mod_nxt   = mod_r;
      tk_nxt    = 1'b0;
      if (seq_start && hdr_en)
      begin
         hleft_nxt = 2'h2; // RL1
         hpat_nxt  = ~hpat_r; // RL2
      end
      else if (bit_tick)
      begin
         if (hleft_r != 2'h0)
         begin
            mod_nxt   = (hleft_r == 2'h2) ? hpat_r[1] : hpat_r[0]; // RL1
            hleft_nxt = hleft_r - 2'h1;
         end
         else
         begin
            // Ahead of the encoder, so every encoding sees it
            mod_nxt = data_bit ^ inv_en; // RL3 RL4
            tk_nxt  = 1'b1;
         end
      end
   end

   always_ff @(posedge field_clk)
   begin
      if (field_rst)
      begin
         // First inversion at the first sequence yields HDR_FIRST
         hpat_r  <= ~HDR_FIRST;
         hleft_r <= 2'h0;
         mod_r   <= 1'b0;
         tk_r    <= 1'b0;
      end
      else
      begin
         hpat_r  <= hpat_nxt;
         hleft_r <= hleft_nxt;
         mod_r   <= mod_nxt;
         tk_r    <= tk_nxt;
      end
   end

   assign mod_bit   = mod_r;
   assign data_take = tk_r;

   // ************************************************************
   // Field to system crossing
   // ************************************************************
   logic [2:0]       st_a_r, st_s_r;
   logic             tg_a_r, tg_s_r, tg_d_r;
   logic [31:0]      rxw_s_r, rxw_s_nxt;
   logic [RXN_W-1:0] rxn_s_r, rxn_s_nxt;

   always_ff @(posedge clk_sys)
   begin
      st_a_r <= {xm_ok, prog_busy, write_mode};
      st_s_r <= st_a_r;
      tg_a_r <= tgl_r;
      tg_s_r <= tg_a_r;
   end

   // Captured word stays put for a full programming time after the toggle
   always_comb
   begin
      rxw_s_nxt = rxw_s_r;
      rxn_s_nxt = rxn_s_r;
      if (tg_s_r != tg_d_r)
      begin
         rxw_s_nxt = rxw_r;
         rxn_s_nxt = rxn_r;
      end
   end

   // ************************************************************
   // AHB-Lite slave
   // ************************************************************
   logic        wr_pend_r, wr_pend_nxt;
   logic [7:0]  wa_r, wa_nxt;
   logic [31:0] rd_r, rd_nxt;
   logic        acc;

   assign acc = hsel && hready && htrans[1];

   always_comb
   begin
      wr_pend_nxt = acc && hwrite;
      wa_nxt      = acc ? haddr : wa_r;
      cfg_nxt     = cfg_r;
      rd_nxt      = rd_r;
      if (wr_pend_r && wa_r == CFG_OFS)
         cfg_nxt = hwdata[7:0];
      if (acc && !hwrite)
      begin
         case (haddr)
            CFG_OFS:  rd_nxt = {24'h000000, cfg_r};
            STAT_OFS: rd_nxt = {29'h0, st_s_r};
            RXW_OFS:  rd_nxt = rxw_s_r;
            RXN_OFS:  rd_nxt = {26'h0, rxn_s_r};
            default:  rd_nxt = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         wr_pend_r <= 1'b0;
         wa_r      <= 8'h00;
         cfg_r     <= CFG_RST;
         rd_r      <= 32'h00000000;
         tg_d_r    <= 1'b0;
         rxw_s_r   <= 32'h00000000;
         rxn_s_r   <= '0;
      end
      else
      begin
         wr_pend_r <= wr_pend_nxt;
         wa_r      <= wa_nxt;
         cfg_r     <= cfg_nxt;
         rd_r      <= rd_nxt;
         tg_d_r    <= tg_s_r;
         rxw_s_r   <= rxw_s_nxt;
         rxn_s_r   <= rxn_s_nxt;
      end
   end

   // Zero wait state, always OKAY
   assign hrdata    = rd_r;
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
endmodule // tag_link
`default_nettype wire

// ### core/tag_pkg.sv
// Constants, types and helpers shared by the tag gap decoder and output options
// How it works
// RL1: With the header option on, a two-bit header 01 or 10 precedes the first block of a sequence.
// RL2: Each new block sequence sends the header with both bits inverted from the previous one.
// RL3: With inverse output on, the modulator is fed the complement of each data bit.
// RL4: Inversion sits ahead of the encoder, so every encoding type gets it.
// RL5: In fast write the reader spaces gaps about 12 clocks for a zero and 27 for a one.
// RL6: In fast write the tag leaves write mode when over 32 field clocks pass without a gap.
// RL7: Start gap 10-50, write gap 8-30 or 8-20, bit intervals per mode, all in field clocks.
// RL8: After the last gap of a good command, programming ends and read mode returns after 64+648 clocks.
// RL9: Header and inverse options work only with master key 6 or 9 and the extended bit set.
// RL10: A bad write command is dropped and read mode restarts at block 1 of the page.
// RL11: All gap timing is counted on the field clock, restarted at each gap start.
// RL12: An interval outside both bit windows of the active mode makes the command invalid.
package tag_pkg;
   // ************************************************************
   // Register map
   // ************************************************************
   localparam logic [7:0] CFG_OFS  = 8'h00;
   localparam logic [7:0] STAT_OFS = 8'h04;
   localparam logic [7:0] RXW_OFS  = 8'h08;
   localparam logic [7:0] RXN_OFS  = 8'h0C;
   localparam logic [7:0] CFG_RST  = 8'h00;
   localparam int KEY_LSB  = 0;
   localparam int XMODE_B  = 4;
   localparam int HDR_B    = 5;
   localparam int INV_B    = 6;
   localparam int FAST_B   = 7;
   localparam logic [3:0] KEY_A = 4'h6;
   localparam logic [3:0] KEY_B = 4'h9;
   // ************************************************************
   // Field clock windows
   // ************************************************************
   localparam int CW = 7;
   localparam logic [CW-1:0] START_GAP_TIME_MIN = 7'h0A;
   localparam logic [CW-1:0] START_GAP_TIME_MAX = 7'h32;
   localparam logic [CW-1:0] WGAP_MIN = 7'h08;
   localparam logic [CW-1:0] NORMAL_WRITE_GAP_TIME_MAX = 7'h1E;
   localparam logic [CW-1:0] WFGAP_MAX = 7'h14;
   localparam logic [CW-1:0] N0_MIN = 7'h10;
   localparam logic [CW-1:0] N0_MAX = 7'h1F;
   localparam logic [CW-1:0] N1_MIN = 7'h30;
   localparam logic [CW-1:0] N1_MAX = 7'h3F;
   localparam logic [CW-1:0] F0_MIN = 7'h08;
   localparam logic [CW-1:0] F0_MAX = 7'h0F;
   localparam logic [CW-1:0] F1_MIN = 7'h18;
   localparam logic [CW-1:0] F1_MAX = 7'h1F;
   localparam logic [CW-1:0] FAST_TMO = 7'h20;
   localparam logic [CW-1:0] NORM_TMO = 7'h3F;
   localparam int PROG_PRE = 64;
   localparam int PROG_MAIN = 648;
   localparam logic [9:0] PROG_CYC = 10'(PROG_PRE + PROG_MAIN);
   localparam logic [2:0] RESTART_BLK = 3'h1;
   localparam logic [1:0] HDR_FIRST = 2'h1;
   localparam int RXN_W = 6;

   typedef enum logic [1:0] {DEC_IDLE, DEC_START_GAP_TIME, DEC_BITS} dec_st_t;
   typedef enum logic [1:0] {LNK_READ, LNK_WRITE, LNK_PROG} lnk_st_t;

   function automatic logic in_win(input logic [CW-1:0] v,
                                   input logic [CW-1:0] lo,
                                   input logic [CW-1:0] hi);
      in_win = (v >= lo) && (v <= hi);
   endfunction
endpackage
